// ==== rtl/ebi_pkg.sv ====
// Shared constants and types for the external bus cycle sizing block
package ebi_pkg;
  // Widths of the internal request and of the external pins
  localparam int ADDR_W = 20;
  localparam int PIN_ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  localparam int FIFO_DEPTH = 32;
  // Request word layout inside the buffer
  localparam int REQ_WDATA_LSB = 0;
  localparam int REQ_ADDR_LSB = 32;
  localparam int REQ_SIZE_LSB = 52;
  localparam int REQ_IACK_BIT = 54;
  localparam int REQ_WR_BIT = 55;
  localparam int REQ_W = 56;
  // Synchronised pin vector layout
  localparam int PIN_AUTO_VECTOR_REQ_BIT = 0;
  localparam int PIN_STOP_BIT = 1;
  localparam int PIN_FAULT_BIT = 2;
  localparam int PIN_ACK_LSB = 3;
  localparam int PIN_DATA_LSB = 5;
  localparam int SYNC_W = 21;
  localparam logic [SYNC_W-1:0] SYNC_RST = 21'h1FFFFF;
  // Operand size of an internal request
  typedef enum logic [1:0] {
    OP_LONG = 2'b00,
    OP_BYTE = 2'b01,
    OP_WORD = 2'b10
  } op_size_t;
  // Size code driven on the pins
  localparam logic [1:0] SIZ_LONG = 2'h0;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  localparam logic [1:0] SIZ_3BYTE = 2'h3;
  // Termination acknowledge pin pairs {hi, lo}
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  // Operand byte counts
  localparam logic [2:0] CNT_BYTE = 3'h1;
  localparam logic [2:0] CNT_WORD = 3'h2;
  localparam logic [2:0] CNT_THREE = 3'h3;
  localparam logic [2:0] CNT_LONG = 3'h4;
  // Bus cycle states, each one half bus clock long except ST_IDLE and ST_WAIT, which can hold for many
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ASRT = 3'b010,
    ST_WDAT = 3'b011,
    ST_WAIT = 3'b100,
    ST_END = 3'b101
  } bus_state_t;
endpackage : ebi_pkg

// ==== rtl/ebi_sync.sv ====
// Two-stage synchroniser for the asynchronous bus inputs
`timescale 1ns/10ps
`default_nettype none
module ebi_sync #(
  parameter int WIDTH = 21,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] i_async, // Raw pin levels
  output logic [WIDTH-1:0] o_sync // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : ebi_sync
`default_nettype wire

// ==== rtl/ebi_req_fifo.sv ====
// Request FIFO with registered head word
`timescale 1ns/10ps
`default_nettype none
module ebi_req_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 32
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_valid, // Write side valid
  output logic o_ready, // Write side ready, low when full
  input wire logic [WIDTH-1:0] i_data, // Write data
  output logic o_valid, // Read side valid, high when not empty
  input wire logic i_ready, // Read side ready
  output logic [WIDTH-1:0] o_data // Head word, from a register
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshake terms
  assign o_ready = (count_r != FULL_CNT);
  assign o_valid = (count_r != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

  // Storage array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_data;
    end
  end

  // Head register always mirrors the slot at the read pointer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= '0;
    end else if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      o_data <= i_data;
    end else begin
      o_data <= mem[rd_ptr_nxt];
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : ebi_req_fifo
`default_nettype wire

// ==== rtl/ebi_bus_cycle.sv ====
// External bus cycle engine with dynamic 8/16-bit port sizing
//
// Behaviour
// - Address strobe asserts one half bus clock after the cycle starts.
// - Read data is captured on the final edge of the cycle.
// - Write cycles drive all sixteen data lines.
// - Write data appears one half clock after address strobe.
// - Read cycles assert data strobe together with address strobe.
// - Write cycles assert data strobe one full clock after address strobe.
// - Acknowledge pair: 11 wait, 10 port8, 01 port16, 00 reserved.
// - Bus fault ends the cycle as failed, with or without acknowledges.
// - Bus fault with stop request raises the bus error exception.
// - Autovector ends only interrupt acknowledge cycles; ignored elsewhere.
// - Word operations start assuming a 16-bit port, moving maximum data.
// - Even long words take two cycles on 16-bit ports; odd ones, and all on 8-bit ports, take four.
// - Size code gives bytes still to move in the current segment.
// - Address gives part base and byte offset; bits 23..20 copy 19.
// - Misaligned long words split into two misaligned word transfers.
// - Byte lane choice by address; byte copied onto the other lane.
// - Word lane placement depends on alignment and port width.
// - Three-byte code appears only in long word to 8-bit port.
// - Read cycles discard the duplicate byte on the unused lane.
// - Size codes: byte 01, word 10, three 11, long 00; held with strobe.
// - Direction changes only at cycle start and holds with strobe.
`timescale 1ns/10ps
`default_nettype none
module ebi_bus_cycle (
  input wire logic i_clk, // System clock, 50 MHz
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_req_valid, // Request valid
  output logic o_req_ready, // Request accepted into buffer
  input wire logic i_req_write, // Request is a write
  input wire logic i_req_iack, // Request is an interrupt acknowledge
  input wire ebi_pkg::op_size_t i_req_size, // Operand size
  input wire logic [ebi_pkg::ADDR_W-1:0] i_req_addr, // Operand address
  input wire logic [ebi_pkg::OPND_W-1:0] i_req_wdata, // Right-aligned data
  output logic o_rsp_valid, // One-cycle completion pulse
  output logic [ebi_pkg::OPND_W-1:0] o_rsp_data, // Right-aligned read data
  output logic o_rsp_fault, // Operation ended by bus fault
  output logic o_rsp_exception, // Bus error exception taken
  output logic o_rsp_autovec, // Vector to be made internally
  output logic [ebi_pkg::PIN_ADDR_W-1:0] o_addr, // Address pins
  output logic o_xfer_size_hi, // Size code high pin
  output logic o_xfer_size_lo, // Size code low pin
  output logic o_dir_write_n, // High read, low write
  output logic o_addr_strobe_n, // Address strobe, active low
  output logic o_data_strobe_n, // Data strobe, active low
  output logic [ebi_pkg::DATA_W-1:0] o_data_out, // Data pins out
  output logic o_data_oe, // Data pins driven when high
  input wire logic [ebi_pkg::DATA_W-1:0] i_data_in, // Data pins in
  input wire logic i_ack_width_hi, // Acknowledge high pin level
  input wire logic i_ack_width_lo, // Acknowledge low pin level
  input wire logic i_bus_fault_in_n, // Bus fault, active low
  input wire logic i_stop_request_n, // Stop request, active low
  input wire logic i_auto_vector_req_n // Autovector, active low
);
  import ebi_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  bus_state_t state_r;
  logic [SYNC_W-1:0] pins_s;
  logic [DATA_W-1:0] s_data;
  logic [1:0] s_ack;
  logic [REQ_W-1:0] q_data;
  logic q_valid;
  logic q_ready;
  op_size_t q_size;
  logic op_wr_r;
  logic op_iack_r;
  op_size_t op_size_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0] ntot_r;
  logic [2:0] tot_r;
  logic [2:0] seg_r;
  logic [OPND_W-1:0] wbuf_r;
  logic [OPND_W-1:0] rbuf_r;
  logic [1:0] siz_r;
  logic fault_r;
  logic exc_r;
  logic auto_vector_req_r;
  logic [2:0] k;
  logic [1:0] pk;
  logic [1:0] pk1;
  logic two_ok;
  logic port8;
  logic port16;
  logic ack_ok;
  logic fault;
  logic auto_vector_req_ok;
  logic term;
  logic good;
  logic [2:0] moved;
  logic [2:0] seg_left;
  logic [7:0] wr_hi;
  logic [7:0] wr_lo;

  // Byte position from the LSB of operand byte idx, byte 0 most significant
  function automatic logic [1:0] bpos(input logic [2:0] n,
                                      input logic [2:0] idx);
    logic [2:0] p;
    p = n - 3'h1 - idx;
    return p[1:0];
  endfunction : bpos

  // Size code from bytes left in the current segment
  function automatic logic [1:0] siz_code(input logic [2:0] n);
    logic [1:0] c;
    c = SIZ_LONG;
    if (n == CNT_BYTE) c = SIZ_BYTE;
    if (n == CNT_WORD) c = SIZ_WORD;
    if (n == CNT_THREE) c = SIZ_3BYTE;
    return c;
  endfunction : siz_code

  // Termination and data pins pass two flops before any decode
  ebi_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_data_in, i_ack_width_hi, i_ack_width_lo, i_bus_fault_in_n,
              i_stop_request_n, i_auto_vector_req_n}),
    .o_sync(pins_s)
  );
  assign s_data = pins_s[PIN_DATA_LSB +: DATA_W];
  assign s_ack = pins_s[PIN_ACK_LSB +: 2];

  // Request buffer; engine drains it only when idle
  ebi_req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_req_valid),
    .o_ready(o_req_ready),
    .i_data({i_req_write, i_req_iack, i_req_size, i_req_addr, i_req_wdata}),
    .o_valid(q_valid),
    .i_ready(q_ready),
    .o_data(q_data)
  );
  assign q_ready = (state_r == ST_IDLE);
  assign q_size = op_size_t'(q_data[REQ_SIZE_LSB +: 2]);

  // Lane selection and termination decode
  always_comb begin
    k = ntot_r - tot_r;
    pk = bpos(ntot_r, k);
    pk1 = pk - 2'h1;
    two_ok = !addr_r[0] && (seg_r >= CNT_WORD);
    wr_hi = wbuf_r[{pk, 3'b000} +: 8];
    wr_lo = two_ok ? wbuf_r[{pk1, 3'b000} +: 8] : wr_hi;
    port8 = (s_ack == ACK_PORT8);
    port16 = (s_ack == ACK_PORT16);
    ack_ok = port8 || port16;
    fault = !pins_s[PIN_FAULT_BIT];
    auto_vector_req_ok = op_iack_r && !pins_s[PIN_AUTO_VECTOR_REQ_BIT];
    term = (state_r == ST_WAIT) && (fault || ack_ok || auto_vector_req_ok);
    good = ack_ok && !fault && !auto_vector_req_ok;
    moved = (port16 && two_ok) ? CNT_WORD : CNT_BYTE;
    seg_left = seg_r - moved;
  end

  // Cycle sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (q_valid) state_r <= ST_ADDR;
        ST_ADDR: state_r <= ST_ASRT;
        ST_ASRT: state_r <= ST_WDAT;
        ST_WDAT: state_r <= ST_WAIT;
        ST_WAIT: if (term) state_r <= ST_END;
        ST_END: begin
          if (fault_r || auto_vector_req_r || (tot_r == '0)) begin
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_ADDR;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Operand bookkeeping: address, bytes left, segment left
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_wr_r <= 1'b0;
      op_iack_r <= 1'b0;
      op_size_r <= OP_BYTE;
      addr_r <= '0;
      ntot_r <= CNT_BYTE;
      tot_r <= '0;
      seg_r <= CNT_BYTE;
      wbuf_r <= '0;
    end else if (state_r == ST_IDLE && q_valid) begin
      op_wr_r <= q_data[REQ_WR_BIT];
      op_iack_r <= q_data[REQ_IACK_BIT];
      op_size_r <= q_size;
      addr_r <= q_data[REQ_ADDR_LSB +: ADDR_W];
      wbuf_r <= q_data[REQ_WDATA_LSB +: OPND_W];
      unique case (q_size)
        OP_BYTE: begin
          ntot_r <= CNT_BYTE;
          tot_r <= CNT_BYTE;
          seg_r <= CNT_BYTE;
        end
        OP_WORD: begin
          ntot_r <= CNT_WORD;
          tot_r <= CNT_WORD;
          seg_r <= CNT_WORD;
        end
        OP_LONG: begin
          ntot_r <= CNT_LONG;
          tot_r <= CNT_LONG;
          // Odd long word runs as two word segments
          seg_r <= q_data[REQ_ADDR_LSB] ? CNT_WORD : CNT_LONG;
        end
        default: begin
          ntot_r <= CNT_BYTE;
          tot_r <= CNT_BYTE;
          seg_r <= CNT_BYTE;
        end
      endcase
    end else if (term && good) begin
      addr_r <= addr_r + ADDR_W'(moved);
      tot_r <= tot_r - moved;
      seg_r <= (seg_left == '0) ? CNT_WORD : seg_left;
    end
  end

  // Read capture from the lane the port uses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rbuf_r <= '0;
    end else if (state_r == ST_IDLE && q_valid) begin
      rbuf_r <= '0;
    end else if (term && good && !op_wr_r) begin
      if (port8 || !addr_r[0]) begin
        rbuf_r[{pk, 3'b000} +: 8] <= s_data[15:8];
      end else begin
        rbuf_r[{pk, 3'b000} +: 8] <= s_data[7:0];
      end
      if (port16 && two_ok) begin
        rbuf_r[{pk1, 3'b000} +: 8] <= s_data[7:0];
      end
    end
  end

  // Pin address, size code and direction, loaded at cycle start
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr <= '0;
      siz_r <= SIZ_BYTE;
      o_dir_write_n <= 1'b1;
    end else if (state_r == ST_ADDR) begin
      o_addr <= {{(PIN_ADDR_W-ADDR_W){addr_r[ADDR_W-1]}}, addr_r};
      siz_r <= siz_code(seg_r);
      o_dir_write_n <= !op_wr_r;
    end
  end
  assign o_xfer_size_hi = siz_r[1];
  assign o_xfer_size_lo = siz_r[0];

  // Strobes and write data drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr_strobe_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_data_oe <= 1'b0;
      o_data_out <= '0;
    end else begin
      unique case (state_r)
        ST_ADDR: begin
          o_addr_strobe_n <= 1'b0;
          o_data_strobe_n <= op_wr_r;
        end
        ST_ASRT: begin
          if (op_wr_r) begin
            o_data_oe <= 1'b1;
            o_data_out <= {wr_hi, wr_lo};
          end
        end
        ST_WDAT: o_data_strobe_n <= 1'b0;
        ST_WAIT: begin
          if (term) begin
            o_addr_strobe_n <= 1'b1;
            o_data_strobe_n <= 1'b1;
            o_data_oe <= 1'b0;
          end
        end
        default: begin
          o_addr_strobe_n <= 1'b1;
          o_data_strobe_n <= 1'b1;
          o_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // Outcome flags of the ending cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_r <= 1'b0;
      exc_r <= 1'b0;
      auto_vector_req_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      fault_r <= 1'b0;
      exc_r <= 1'b0;
      auto_vector_req_r <= 1'b0;
    end else if (term) begin
      fault_r <= fault;
      exc_r <= fault && !pins_s[PIN_STOP_BIT];
      auto_vector_req_r <= auto_vector_req_ok && !fault;
    end
  end

  // Completion report to the internal master
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= '0;
      o_rsp_fault <= 1'b0;
      o_rsp_exception <= 1'b0;
      o_rsp_autovec <= 1'b0;
    end else begin
      o_rsp_valid <= (state_r == ST_END) &&
                     (fault_r || auto_vector_req_r || (tot_r == '0));
      if (state_r == ST_END) begin
        o_rsp_data <= rbuf_r;
        o_rsp_fault <= fault_r;
        o_rsp_exception <= exc_r;
        o_rsp_autovec <= auto_vector_req_r;
      end
    end
  end

  AST_AS_HALF: assert property (
    (state_r == ST_ADDR) |-> o_addr_strobe_n ##1 !o_addr_strobe_n)
    else $error("address strobe not one half clock after start");
  AST_WR_ALL_LINES: assert property (
    (state_r == ST_WAIT && op_wr_r) |-> o_data_oe)
    else $error("write cycle not driving data lines");
  AST_WR_DATA_LATE: assert property (
    ($fell(o_addr_strobe_n) && op_wr_r) |-> !o_data_oe ##1 o_data_oe)
    else $error("write data not one half clock after strobe");
  AST_RD_DS_WITH_AS: assert property (
    ($fell(o_addr_strobe_n) && !op_wr_r) |-> $fell(o_data_strobe_n))
    else $error("read data strobe not with address strobe");
  AST_WR_DS_FULL: assert property (
    ($fell(o_addr_strobe_n) && op_wr_r) |->
      o_data_strobe_n ##1 o_data_strobe_n ##1 !o_data_strobe_n)
    else $error("write data strobe not one clock after strobe");
  AST_WAIT_HOLD: assert property (
    (state_r == ST_WAIT && !ack_ok && !fault && !auto_vector_req_ok) |=>
      (state_r == ST_WAIT && !o_addr_strobe_n))
    else $error("cycle ended without termination");
  AST_FAULT_ENDS: assert property (
    (state_r == ST_WAIT && fault) |-> ##2 (o_rsp_valid && o_rsp_fault))
    else $error("bus fault did not fail the operation");
  AST_EXC: assert property (
    (state_r == ST_WAIT && fault && !pins_s[PIN_STOP_BIT]) |->
      ##2 o_rsp_exception)
    else $error("bus error exception missing");
  AST_AUTO_VECTOR_REQ_IGNORED: assert property (
    (state_r == ST_WAIT && !op_iack_r && !ack_ok && !fault) |=>
      (state_r == ST_WAIT))
    else $error("autovector honoured outside acknowledge cycle");
  AST_WORD_WIDE: assert property (
    (state_r == ST_IDLE && q_valid && q_size == OP_WORD) |=>
      ##1 (siz_r == SIZ_WORD))
    else $error("word operation not started as word");
  AST_ADDR_EXT: assert property (
    o_addr[PIN_ADDR_W-1:ADDR_W] == {(PIN_ADDR_W-ADDR_W){o_addr[ADDR_W-1]}})
    else $error("upper address bits do not copy bit 19");
  AST_BYTE_DUP: assert property (
    (o_data_oe && siz_r == SIZ_BYTE) |-> (o_data_out[15:8] == o_data_out[7:0]))
    else $error("byte not copied to both lanes");
  AST_THREE_ONLY: assert property (
    (!o_addr_strobe_n && siz_r == SIZ_3BYTE) |->
      (op_size_r == OP_LONG && tot_r == CNT_THREE))
    else $error("three byte code outside long word sequence");
  AST_HOLD_WITH_AS: assert property (
    (!o_addr_strobe_n && $past(!o_addr_strobe_n)) |->
      ($stable(siz_r) && $stable(o_dir_write_n) && $stable(o_addr)))
    else $error("size, direction or address changed under strobe");

  COV_LONG_8BIT: cover property (
    state_r == ST_WAIT && port8 && siz_r == SIZ_3BYTE);
  COV_WORD_16BIT: cover property (
    term && good && port16 && two_ok && op_wr_r);
  COV_FAULT_EXC: cover property (o_rsp_valid && o_rsp_exception);
  COV_AUTOVEC: cover property (o_rsp_valid && o_rsp_autovec);
endmodule : ebi_bus_cycle
`default_nettype wire

// ==== sim/ext_mem.sv ====
// Behavioural external memory that answers each bus cycle
`timescale 1ns/10ps
`default_nettype none
module ext_mem (
  input wire logic i_clk, // System clock
  input wire logic [23:0] i_addr, // Address pins
  input wire logic [1:0] i_siz, // Size code pins
  input wire logic i_as_n, // Address strobe
  input wire logic i_wr_n, // Direction, low write
  input wire logic [15:0] i_wd, // Write data pins
  input wire logic i_port8, // Act as an 8-bit port
  input wire logic [7:0] i_wait, // Cycles before the end
  input wire logic [1:0] i_flt, // 1 fault, 2 fault with stop
  input wire logic i_noack, // Withhold width acks
  output logic [15:0] o_rd = 16'h0, // Read data pins
  output logic [1:0] o_ack = 2'h3, // Acks {hi, lo}
  output logic o_flt_n = 1'b1, // Bus fault
  output logic o_stop_n = 1'b1 // Stop request
);
  logic [7:0] mem [256];
  logic [7:0] cnt = 8'h0;
  logic [7:0] a;
  assign a = i_addr[7:0];
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
  // Released lines idle high or toggle; terminations held until AS rises
  always @(posedge i_clk) begin
    if (i_as_n) begin
      cnt <= 8'h0;
      o_ack <= 2'h3;
      o_flt_n <= 1'b1;
      o_stop_n <= 1'b1;
      o_rd <= ~o_rd;
    end else begin
      cnt <= cnt + 8'h1;
      o_rd <= i_port8 ? {mem[a], ~mem[a]} :
              {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
      if (cnt == i_wait && i_flt != 2'h0) begin
        o_flt_n <= 1'b0;
        o_stop_n <= (i_flt != 2'h2);
      end else if (cnt == i_wait && !i_noack) begin
        o_ack <= i_port8 ? 2'h2 : 2'h1;
        if (!i_wr_n && (i_port8 || !a[0])) mem[a] <= i_wd[15:8];
        if (!i_wr_n && !i_port8 && a[0]) mem[a] <= i_wd[7:0];
        if (!i_wr_n && !i_port8 && !a[0] && i_siz != 2'h1)
          mem[a + 8'h1] <= i_wd[7:0];
      end
    end
  end
endmodule : ext_mem
`default_nettype wire

// ==== sim/tb_ebi_bus_cycle.sv ====
// Self-checking bench for the external bus cycle engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_ebi_bus_cycle;
  import ebi_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0;
  logic i_req_iack = 0, i_auto_vector_req_n = 1, port8 = 0, noack = 0;
  op_size_t i_req_size = OP_BYTE;
  logic [19:0] i_req_addr = 0;
  logic [31:0] i_req_wdata = 0, o_rsp_data, rsp;
  logic [23:0] o_addr;
  logic [15:0] o_data_out, i_data_in, wd, sizes;
  logic [1:0] ack, flt = 0;
  logic [7:0] wt = 8'h3, ncyc;
  logic [2:0] rf;
  logic o_req_ready, o_rsp_valid, o_rsp_fault, o_rsp_exception;
  logic o_rsp_autovec, o_xfer_size_hi, o_xfer_size_lo, o_dir_write_n;
  logic o_addr_strobe_n, o_data_strobe_n, o_data_oe, flt_n, stop_n;
  int fails = 0, n_compared = 0, n_rsp = 0, cyc = 0;
  ebi_bus_cycle ebi_bus_cycle_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .i_req_write(i_req_write), .i_req_iack(i_req_iack),
    .i_req_size(i_req_size), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_rsp_fault(o_rsp_fault),
    .o_rsp_exception(o_rsp_exception), .o_rsp_autovec(o_rsp_autovec),
    .o_addr(o_addr), .o_xfer_size_hi(o_xfer_size_hi),
    .o_xfer_size_lo(o_xfer_size_lo), .o_dir_write_n(o_dir_write_n),
    .o_addr_strobe_n(o_addr_strobe_n), .o_data_strobe_n(o_data_strobe_n),
    .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .i_data_in(i_data_in), .i_ack_width_hi(ack[1]),
    .i_ack_width_lo(ack[0]), .i_bus_fault_in_n(flt_n),
    .i_stop_request_n(stop_n), .i_auto_vector_req_n(i_auto_vector_req_n));
  ext_mem ext_mem_inst (.i_clk(i_clk), .i_addr(o_addr),
    .i_siz({o_xfer_size_hi, o_xfer_size_lo}), .i_as_n(o_addr_strobe_n),
    .i_wr_n(o_dir_write_n), .i_wd(o_data_out), .i_port8(port8),
    .i_wait(wt), .i_flt(flt), .i_noack(noack), .o_rd(i_data_in),
    .o_ack(ack), .o_flt_n(flt_n), .o_stop_n(stop_n));
  initial forever #10 i_clk = ~i_clk;
  // Log size code, check address and direction at each cycle start
  always @(negedge o_addr_strobe_n) begin
    #1;
    sizes = {sizes[13:0], o_xfer_size_hi, o_xfer_size_lo};
    ncyc++;
    `CHK(o_addr[23:20], {4{o_addr[19]}})
    `CHK(o_dir_write_n, !i_req_write)
  end
  // Capture write lanes once data strobe says they are valid
  always @(negedge o_data_strobe_n) if (o_dir_write_n === 1'b0) begin
    #1;
    wd = o_data_out;
    `CHK(o_data_oe, 1'b1)
  end
  // Responses and run limit
  always @(posedge i_clk) begin
    cyc++;
    if (o_rsp_valid === 1'b1) begin
      n_rsp++;
      rsp = o_rsp_data;
      rf = {o_rsp_fault, o_rsp_exception, o_rsp_autovec};
    end
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic op(input logic w, k, input op_size_t s,
                    input logic [19:0] ad, input logic [31:0] d);
    int n, got;
    @(negedge i_clk);
    sizes = 16'h0;
    ncyc = 8'h0;
    got = n_rsp;
    {i_req_write, i_req_iack, i_req_size, i_req_addr} = {w, k, s, ad};
    i_req_wdata = d;
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    i_req_valid = 1'b0;
    for (n = 0; n < 600 && n_rsp == got; n++) @(negedge i_clk);
  endtask : op
  task t_write;
    op(1, 0, OP_WORD, 20'h20, 32'hBEEF);
    `CHK(wd, 16'hBEEF)
    `CHK(ncyc, 8'h1)
    op(1, 0, OP_BYTE, 20'h31, 32'h3C);
    `CHK(wd, 16'h3C3C)
    port8 = 1;
    op(1, 0, OP_LONG, 20'h40, 32'h11223344);
    `CHK(sizes[7:0], 8'h39)
    `CHK(wd, 16'h4444)
    op(0, 0, OP_WORD, 20'h70, 0);
    `CHK(rsp, 32'h2A2B)
    `CHK(ncyc, 8'h2)
    port8 = 0;
    $display("test write done");
  endtask : t_write
  task t_read;
    op(0, 0, OP_LONG, 20'h40, 0);
    `CHK(rsp, 32'h11223344)
    `CHK(sizes[3:0], 4'h2)
    wt = 8'h14;
    op(0, 0, OP_WORD, 20'h20, 0);
    `CHK(rsp, 32'hBEEF)
    op(0, 0, OP_BYTE, 20'h80031, 0);
    `CHK(rsp, 32'h3C)
    wt = 8'h3;
    op(0, 0, OP_WORD, 20'h51, 0);
    `CHK(rsp, 32'h0B08)
    `CHK(sizes[3:0], 4'h9)
    op(0, 0, OP_LONG, 20'h61, 0);
    `CHK(rsp, 32'h3B38393E)
    `CHK(sizes[7:0], 8'h99)
    $display("test read done");
  endtask : t_read
  task t_end;
    flt = 2'h1;
    op(0, 0, OP_WORD, 20'h20, 0);
    `CHK(rf, 3'h4)
    flt = 2'h2;
    op(1, 0, OP_WORD, 20'h20, 0);
    `CHK(rf, 3'h6)
    flt = 2'h0;
    i_auto_vector_req_n = 0;
    op(0, 0, OP_BYTE, 20'h20, 0);
    `CHK({rf, rsp[7:0]}, 11'h0BE)
    noack = 1;
    op(0, 1, OP_BYTE, 20'h20, 0);
    `CHK(rf, 3'h1)
    {noack, i_auto_vector_req_n} = 2'b01;
    $display("test termination done");
  endtask : t_end
  task t_fifo;
    int acc, base, n;
    logic r;
    acc = 0;
    base = n_rsp;
    wt = 8'hFF;
    @(negedge i_clk);
    i_req_valid = 1'b1;
    for (n = 0; n < 40; n++) begin
      r = o_req_ready;
      @(negedge i_clk);
      if (r) acc++;
    end
    i_req_valid = 1'b0;
    `CHK(o_req_ready, 1'b0)
    `CHK(acc >= 32 && acc <= 34, 1'b1)
    wt = 8'h3;
    for (n = 0; n < 3000 && n_rsp < base + acc; n++) @(negedge i_clk);
    `CHK(n_rsp - base, acc)
    $display("test buffer done");
  endtask : t_fifo
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // Reset, then the scenarios in turn
  initial begin
    repeat (2) @(negedge i_clk);
    `CHK({o_addr_strobe_n, o_data_oe, o_dir_write_n}, 3'b101)
    i_rst_n = 1;
    t_write();
    t_read();
    t_end();
    t_fifo();
    give_verdict();
  end
endmodule : tb_ebi_bus_cycle
`default_nettype wire
